// ==== logic/dac_stage_regs.svh ====
// register indices, field positions and reset values of the precision-mode code staging bank
// assumes: included by bare name; byte address of a register is four times its index
`ifndef DAC_STAGE_REGS_SVH
`define DAC_STAGE_REGS_SVH

`define IDX_LOAD_MASK       8'h37
`define IDX_OUTPUT_CODE     8'h38
`define IDX_OUTPUT_PAGE     8'h3e
`define IDX_CHANNEL_SELECT  8'h41
`define IDX_INPUT_PAGE      8'h42
`define IDX_SW_LOAD         8'h45
`define IDX_STAGED_INPUT    8'h46

`define CODE_MSB            23
`define CODE_LSB            8
`define CTRL_BIT            0

`define RST_CODE_REG        24'h000000
`define RST_BYTE_REG        8'h00
`define RST_CODE            16'h0000

`endif

// ==== logic/dac_stage_pkg.sv ====
// types shared by the staging bank and its bus port
// assumes: compiled before every module of the bank
package dac_stage_pkg;

    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_wait = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  index;
        logic [31:0] wdata;
    } reg_req_t;

endpackage

// ==== logic/ahb_reg_port.sv ====
// ahb-lite slave front end: one wait state per transfer, single word transfers only
// assumes: sole slave on the bus, so hready is this block's own hreadyout
`timescale 1ns/1ps
module ahb_reg_port
    import dac_stage_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output reg_req_t         req,
    input  wire logic [31:0] rdata
);

    bus_state_t  state_r;
    bus_state_t  state_nxt;
    logic        wr_r;
    logic        index_ok_r;
    logic [7:0]  index_r;
    logic        taken;
    logic        word_access;

    assign word_access = (hsize == 3'h2) && (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h000000);
    assign taken       = hsel && htrans[1] && hready;
    assign state_nxt   = (state_r == st_idle && taken) ? st_wait : st_idle;

    // request is offered to the bank in the wait-state cycle of the data phase, taken at the end of that cycle
    assign req.wr    = (state_r == st_wait) && wr_r && index_ok_r;
    assign req.rd    = (state_r == st_wait) && !wr_r && index_ok_r;
    assign req.index = index_r;
    assign req.wdata = hwdata;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= st_idle;
            wr_r       <= 1'b0;
            index_ok_r <= 1'b0;
            index_r    <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (taken) begin
                wr_r       <= hwrite;
                index_ok_r <= word_access;
                index_r    <= haddr[9:2];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end else begin
            hreadyout <= (state_nxt == st_idle);
            hresp     <= 1'b0;
            if (state_r == st_wait) begin
                hrdata <= req.rd ? rdata : 32'h00000000;
            end
        end
    end

endmodule // ahb_reg_port

// ==== logic/load_pulse_gen.sv ====
// turns the active-low hardware load pin into a one-cycle load pulse on its falling edge
// assumes: pin already synchronous to core_clk
`timescale 1ns/1ps
module load_pulse_gen (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic hardware_load_pin_n,
    output logic      load_pulse
);

    logic pin_prev_r;
    logic fall;

    assign fall = pin_prev_r && !hardware_load_pin_n;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_prev_r <= 1'b1;
            load_pulse <= 1'b0;
        end else begin
            pin_prev_r <= hardware_load_pin_n;
            load_pulse <= fall;
        end
    end

endmodule // load_pulse_gen

// ==== logic/dac_code_staging_regs_24b.sv ====
// precision-mode code staging bank: output code, page registers, page copy select, software load
// assumes: single ahb-lite master, load pin synchronous to core_clk
`timescale 1ns/1ps
`include "dac_stage_regs.svh"
module dac_code_staging_regs_24b
    import dac_stage_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        hardware_load_pin_n,
    output logic [15:0]      active_output_code
);

    reg_req_t    req;
    logic [31:0] rdata;
    logic        hw_pulse;

    logic [15:0] output_page_r;
    logic [15:0] input_page_r;
    logic [15:0] staged_input_code_r;
    logic        page_copy_enable_r;
    logic        hardware_load_mask_r;
    logic        software_load_request_r;

    logic [15:0] active_nxt;
    logic [15:0] staged_nxt;
    logic [15:0] wr_code;
    logic        wr_out_code;
    logic        wr_out_page;
    logic        wr_in_page;
    logic        wr_staged;
    logic        wr_select;
    logic        wr_mask;
    logic        wr_sw_load;
    logic        do_load;

    ahb_reg_port u_port (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .req       (req),
        .rdata     (rdata)
    );

    load_pulse_gen u_pin (
        .core_clk            (core_clk),
        .sys_rst             (sys_rst),
        .hardware_load_pin_n (hardware_load_pin_n),
        .load_pulse          (hw_pulse)
    );

    // write decode; only the code field and bit 0 are ever taken from hwdata
    assign wr_code     = req.wdata[`CODE_MSB:`CODE_LSB];
    assign wr_out_code = req.wr && (req.index == `IDX_OUTPUT_CODE);
    assign wr_out_page = req.wr && (req.index == `IDX_OUTPUT_PAGE);
    assign wr_in_page  = req.wr && (req.index == `IDX_INPUT_PAGE);
    assign wr_staged   = req.wr && (req.index == `IDX_STAGED_INPUT);
    assign wr_select   = req.wr && (req.index == `IDX_CHANNEL_SELECT);
    assign wr_mask     = req.wr && (req.index == `IDX_LOAD_MASK);
    assign wr_sw_load  = wr_sw_load_bit(req);

    function automatic logic wr_sw_load_bit(input reg_req_t r);
        wr_sw_load_bit = r.wr && (r.index == `IDX_SW_LOAD) && r.wdata[`CTRL_BIT];
    endfunction

    // software and unmasked hardware loads share one transfer path
    assign do_load = software_load_request_r || (hw_pulse && !hardware_load_mask_r);

    // output code writes, and output page writes with page copy enabled, win over a load in the same cycle
    assign active_nxt = wr_out_code                          ? wr_code :
                        (wr_out_page && page_copy_enable_r)  ? wr_code :
                        do_load                              ? staged_input_code_r :
                                                               active_output_code;
    assign staged_nxt = wr_staged                            ? wr_code :
                        (wr_in_page && page_copy_enable_r)   ? wr_code :
                                                               staged_input_code_r;

    // read mux; reserved bits and the load bit read zero
    assign rdata = (req.index == `IDX_OUTPUT_CODE)    ? {8'h00, active_output_code, 8'h00} :
                   (req.index == `IDX_OUTPUT_PAGE)    ? {8'h00, output_page_r, 8'h00} :
                   (req.index == `IDX_INPUT_PAGE)     ? {8'h00, input_page_r, 8'h00} :
                   (req.index == `IDX_STAGED_INPUT)   ? {8'h00, staged_input_code_r, 8'h00} :
                   (req.index == `IDX_CHANNEL_SELECT) ? {31'h00000000, page_copy_enable_r} :
                   (req.index == `IDX_LOAD_MASK)      ? {31'h00000000, hardware_load_mask_r} :
                                                        32'h00000000;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_output_code  <= `RST_CODE;
            staged_input_code_r <= `RST_CODE;
        end else begin
            active_output_code  <= active_nxt;
            staged_input_code_r <= staged_nxt;
        end
    end

    // page registers store every write regardless of select
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            output_page_r <= `RST_CODE;
            input_page_r  <= `RST_CODE;
        end else begin
            if (wr_out_page) begin
                output_page_r <= wr_code;
            end
            if (wr_in_page) begin
                input_page_r <= wr_code;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            page_copy_enable_r      <= 1'b0;
            hardware_load_mask_r    <= 1'b0;
            software_load_request_r <= 1'b0;
        end else begin
            if (wr_select) begin
                page_copy_enable_r <= req.wdata[`CTRL_BIT];
            end
            if (wr_mask) begin
                hardware_load_mask_r <= req.wdata[`CTRL_BIT];
            end
            software_load_request_r <= wr_sw_load;
        end
    end

endmodule // dac_code_staging_regs_24b

// ==== verif/dac_code_staging_regs_24b_assertions.sv ====
// concurrent checks on the port behaviour of the precision-mode code staging bank
// assumes: bound to dac_code_staging_regs_24b as sole bus slave, hready tied to hreadyout
`timescale 1ns/1ps
module dac_code_staging_regs_24b_checker (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        hardware_load_pin_n,
    input wire logic [15:0] active_output_code
);
    logic        wr_dp_r;
    logic        rd_r;
    logic [31:0] addr_r;
    wire         taken  = hsel && htrans[1] && hready;
    wire  [15:0] code_w = hwdata[23:8];
    // remembers the transfer now in its data phase
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_dp_r <= 1'b0;
            rd_r    <= 1'b0;
            addr_r  <= 32'h0;
        end else begin
            wr_dp_r <= taken && hwrite && (hsize == 3'h2);
            rd_r    <= taken && !hwrite;
            addr_r  <= taken ? haddr : addr_r;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
    wait_state_a: assert property (taken |=> !hreadyout) else $error("missing wait state");
    one_wait_a: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
    reset_zero_a: assert property (disable iff (1'b0) sys_rst |-> active_output_code == 16'h0 && hrdata == 32'h0)
        else $error("outputs not cleared in reset");
    direct_write_a: assert property (wr_dp_r && addr_r == 32'he0 |=> active_output_code == $past(code_w))
        else $error("active code not written");
    code_hold_a: assert property ($changed(active_output_code) |-> $past(wr_dp_r) || $past(wr_dp_r, 2)
        || ($past(hardware_load_pin_n, 3) && !$past(hardware_load_pin_n, 2))) else $error("spurious code change");
    reserved_zero_a: assert property (rd_r && addr_r inside {32'he0, 32'hf8, 32'h108, 32'h118}
        |=> hrdata[31:24] == 8'h0 && hrdata[7:0] == 8'h0) else $error("reserved bits read nonzero");
    select_bits_a: assert property (rd_r && addr_r == 32'h104 |=> hrdata[31:1] == 31'h0)
        else $error("select reserved bits nonzero");
    load_reads_zero_a: assert property (rd_r && addr_r == 32'h114 |=> hrdata == 32'h0)
        else $error("load bit reads nonzero");
    cov_write: cover property (wr_dp_r && addr_r == 32'he0);
    cov_pin: cover property ($fell(hardware_load_pin_n));
    cov_load_read: cover property (rd_r && addr_r == 32'h114);
endmodule // dac_code_staging_regs_24b_checker

// ==== verif/dac_code_staging_regs_24b_tb_top.sv ====
// register-level bench for the precision-mode code staging bank
// assumes: bench is the only bus master; hready fed back from hreadyout
`timescale 1ns/1ps
`include "dac_stage_regs.svh"
module dac_code_staging_regs_24b_tb_top;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hardware_load_pin_n = 1'b1;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [15:0] active_output_code;
    logic [31:0] q;
    logic [7:0]  idxs [7] = '{`IDX_LOAD_MASK, `IDX_OUTPUT_CODE, `IDX_OUTPUT_PAGE, `IDX_CHANNEL_SELECT,
                              `IDX_INPUT_PAGE, `IDX_SW_LOAD, `IDX_STAGED_INPUT};
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    dac_code_staging_regs_24b uut (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hardware_load_pin_n(hardware_load_pin_n),
        .active_output_code(active_output_code));
    function automatic logic [31:0] a(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= ad;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [31:0] ad, input logic [31:0] exp, input string name);
        xfer(1'b0, ad, 32'h0);
        check(name, q, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic pin_pulse;
        hardware_load_pin_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        hardware_load_pin_n <= 1'b1;
        @(posedge core_clk);
    endtask
    task finish_test;
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            finish_test;
        end
    end
    initial begin
        sys_rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        check("code", {16'h0, active_output_code}, 32'h0);
        foreach (idxs[i]) rd(a(idxs[i]), 32'h0, "reset");
        xfer(1'b1, a(`IDX_OUTPUT_CODE), 32'hffffffff);
        check("code", {16'h0, active_output_code}, 32'hffff);
        rd(a(`IDX_OUTPUT_CODE), 32'h00ffff00, "out");
        xfer(1'b1, a(`IDX_OUTPUT_PAGE), 32'ha5123456);
        rd(a(`IDX_OUTPUT_PAGE), 32'h00123400, "opage");
        check("code", {16'h0, active_output_code}, 32'hffff);
        xfer(1'b1, a(`IDX_CHANNEL_SELECT), 32'hff);
        rd(a(`IDX_CHANNEL_SELECT), 32'h1, "sel");
        xfer(1'b1, a(`IDX_OUTPUT_PAGE), 32'h00abcd00);
        check("code", {16'h0, active_output_code}, 32'habcd);
        xfer(1'b1, a(`IDX_INPUT_PAGE), 32'h00567800);
        rd(a(`IDX_STAGED_INPUT), 32'h00567800, "staged");
        xfer(1'b1, a(`IDX_SW_LOAD), 32'h0);
        @(posedge core_clk);
        check("code", {16'h0, active_output_code}, 32'habcd);
        xfer(1'b1, a(`IDX_SW_LOAD), 32'h1);
        @(posedge core_clk);
        check("code", {16'h0, active_output_code}, 32'h5678);
        rd(a(`IDX_SW_LOAD), 32'h0, "swload");
        xfer(1'b1, a(`IDX_STAGED_INPUT), 32'h00222200);
        repeat (4) @(posedge core_clk);
        check("code", {16'h0, active_output_code}, 32'h5678);
        pin_pulse;
        check("code", {16'h0, active_output_code}, 32'h2222);
        xfer(1'b1, a(`IDX_LOAD_MASK), 32'h1);
        xfer(1'b1, a(`IDX_STAGED_INPUT), 32'h00333300);
        pin_pulse;
        check("code", {16'h0, active_output_code}, 32'h2222);
        hsize <= 3'h0;
        xfer(1'b1, a(`IDX_OUTPUT_CODE), 32'h00111100);
        hsize <= 3'h2;
        check("code", {16'h0, active_output_code}, 32'h2222);
        xfer(1'b1, a(`IDX_CHANNEL_SELECT), 32'h0);
        xfer(1'b1, a(`IDX_INPUT_PAGE), 32'h00444400);
        rd(a(`IDX_STAGED_INPUT), 32'h00333300, "staged");
        xfer(1'b1, a(8'hff), 32'hffffffff);
        rd(a(8'hff), 32'h0, "unmapped");
        finish_test;
    end
endmodule // dac_code_staging_regs_24b_tb_top
bind dac_code_staging_regs_24b dac_code_staging_regs_24b_checker chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .hardware_load_pin_n(hardware_load_pin_n), .active_output_code(active_output_code));
